// *** pkg/rqa_defs.svh ***
`ifndef RQA_DEFS_SVH
`define RQA_DEFS_SVH

// Byte address of the processor level register.
`define RQA_CPU_LEVEL_ADDR   32'h41007110
// Field position of the processor level.
`define RQA_CPU_LEVEL_MSB    1
`define RQA_CPU_LEVEL_LSB    0
// Reset value of the processor level.
`define RQA_CPU_LEVEL_RST    2'h0
// Fixed level of the trace buffer master.
`define RQA_TRACE_LEVEL      2'h3
// Fixed level of the debug service unit.
`define RQA_DEBUG_LEVEL      2'h1
// Address bits decoded by the slave.
`define RQA_DECODE_MSB       31
`define RQA_DECODE_LSB       2

`endif

// *** pkg/rqa_pkg.sv ***
package rqa_pkg;

    // Quality-of-service level of one access.
    typedef enum logic [1:0] {
        RQA_QOS_BACKGROUND = 2'h0,
        RQA_QOS_BANDWIDTH  = 2'h1,
        RQA_QOS_LATENCY    = 2'h2,
        RQA_QOS_CRITICAL   = 2'h3
    } rqa_qos_e;

    // State of the bus slave data phase.
    typedef enum logic {
        RQA_BUS_IDLE,
        RQA_BUS_DATA
    } rqa_bus_e;

endpackage : rqa_pkg

// *** pkg/rqa_req_if.sv ***
`timescale 1ns/10ps
// Carries the request vector and per-port levels to the ranking core.
interface rqa_req_if #(parameter int NPORT = 5);
    logic [NPORT-1:0]   req;    // Ports requesting this cycle.
    logic [2*NPORT-1:0] level;  // Two level bits per port.
    logic [NPORT-1:0]   pick;   // One-hot winner, zero if none.
    modport src (output req, output level, input pick);
    modport core (input req, input level, output pick);
endinterface : rqa_req_if

// *** rtl/rqa_rank.sv ***
`timescale 1ns/10ps
// Combinational ranking of concurrent requests by level then port number.
module rqa_rank #(
    parameter int NPORT = 5
) (
    rqa_req_if.core bus
);

    // Walks ports from the highest number down so the lowest number wins ties.
    always_comb begin
        logic [1:0] best;
        best     = 2'h0;
        bus.pick = '0;
        for (int i = NPORT - 1; i >= 0; i--) begin
            // Higher level wins; equal level taken by the lower port.
            if (bus.req[i] &&
                (bus.pick == '0 || bus.level[2*i +: 2] >= best)) begin
                best     = bus.level[2*i +: 2];
                bus.pick = '0;
                bus.pick[i] = 1'b1; // Only one winner.
            end
        end
    end

endmodule : rqa_rank

// *** rtl/rqa_arbiter.sv ***
`timescale 1ns/10ps
`include "rqa_defs.svh"
// What this block does
// - Each master has own level, sent with access.
// - Levels: background, bandwidth, latency, critical.
// - Levels zero and one wait one cycle.
// - Rank by level first, port number breaks ties.
// - Lowest port number wins static priority.
// - Trace buffer level fixed at critical.
// - Debug unit level fixed at bandwidth.
// - Processor level register, bits one-zero, resets zero.
module rqa_arbiter
    import rqa_pkg::*;
#(
    parameter int PORT_CPU   = 0,
    parameter int PORT_TRACE = 1,
    parameter int PORT_DEBUG = 2,
    parameter int PORT_DMA   = 3,
    parameter int PORT_CAN   = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // AHB-Lite slave for the processor level register.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Requests from the five masters, one bit per port.
    input  wire logic [4:0]  ram_req,
    // Levels supplied by the memory controller and CAN masters.
    input  wire logic [1:0]  dma_level,
    input  wire logic [1:0]  can_level,
    // One-hot grant and the level handed to the RAM with the access.
    output logic      [4:0]  ram_grant,
    output logic      [1:0]  ram_level,
    output logic             ram_valid
);

    localparam int NPORT = 5;

    logic [1:0]       cpu_level_r;   // Processor level field.
    rqa_bus_e         bus_state_r;   // Data phase pending.
    logic             wr_pend_r;     // Pending phase is a write.
    logic [NPORT-1:0] pick;          // Winner this cycle.
    logic [1:0]       pick_level;    // Level of the winner.
    logic [NPORT-1:0] hold_r;        // Low-level winner waiting one cycle.
    logic [1:0]       hold_level_r;  // Level of the held winner.
    logic [2:0]       pick_idx;      // Port number of the winner.
    logic [1:0]       rd_level;      // Level as a read will see it.

    rqa_req_if #(.NPORT(NPORT)) req_bus ();

    // Address decode: match the aligned word of the level register.
    function automatic logic hits_level(input logic [31:0] a);
        hits_level = a[`RQA_DECODE_MSB:`RQA_DECODE_LSB] ==
                     30'(`RQA_CPU_LEVEL_ADDR >> 2);
    endfunction : hits_level

    // Builds the per-port level vector that the ranking core sees.
    always_comb begin
        req_bus.req   = ram_req & ~hold_r;
        req_bus.level = '0;
        // Processor level from the register.
        req_bus.level[2*PORT_CPU +: 2]   = cpu_level_r;
        // Fixed trace buffer level.
        req_bus.level[2*PORT_TRACE +: 2] = `RQA_TRACE_LEVEL;
        // Fixed debug unit level.
        req_bus.level[2*PORT_DEBUG +: 2] = `RQA_DEBUG_LEVEL;
        // Externally controlled levels.
        req_bus.level[2*PORT_DMA +: 2]   = dma_level;
        req_bus.level[2*PORT_CAN +: 2]   = can_level;
    end

    rqa_rank #(.NPORT(NPORT)) u_rank (
        .bus (req_bus)
    );

    // Level and port number of the current winner.
    always_comb begin
        pick       = req_bus.pick;
        pick_level = 2'h0;
        pick_idx   = 3'h0;
        for (int i = 0; i < NPORT; i++) begin
            // The pick is one-hot, so at most one port matches.
            if (pick[i]) begin
                pick_level = req_bus.level[2*i +: 2];
                pick_idx   = 3'(i);
            end
        end
    end

    // A low-level winner is held one cycle before its grant.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_r       <= '0;
            hold_level_r <= 2'h0;
        end else if (hold_r != '0) begin
            hold_r <= '0;
        end else if (pick != '0 && pick_level <= RQA_QOS_BANDWIDTH) begin
            hold_r       <= pick;
            hold_level_r <= pick_level;
        end
    end

    // Grant register: one grant per cycle, level travels with it.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ram_grant <= '0;
            ram_level <= 2'h0;
            ram_valid <= 1'b0;
        end else if (hold_r != '0) begin
            // The held low-level access goes now.
            ram_grant <= hold_r;
            ram_level <= hold_level_r;
            ram_valid <= 1'b1;
        end else if (pick != '0 && pick_level > RQA_QOS_BANDWIDTH) begin
            // Latency classes are granted without a wait state.
            ram_grant <= pick;
            ram_level <= pick_level;
            ram_valid <= 1'b1;
        end else begin
            ram_grant <= '0;
            ram_level <= 2'h0;
            ram_valid <= 1'b0;
        end
    end

    // Never two grants at once.
    a_grant_onehot: assert property (@(posedge clk_sys)
        disable iff (reset) $onehot0(ram_grant))
        else $error("more than one grant");

    // Valid and the grant vector rise and fall together.
    a_valid_grant: assert property (@(posedge clk_sys)
        disable iff (reset) ram_valid == (ram_grant != '0))
        else $error("valid and grant disagree");

    // An idle grant register carries no level.
    a_idle_zero: assert property (@(posedge clk_sys)
        disable iff (reset) !ram_valid |-> ram_level == 2'h0)
        else $error("level without grant");

    // Only one port can be held, and only at a low level.
    a_hold_low: assert property (@(posedge clk_sys)
        disable iff (reset)
        (hold_r != '0) |-> $onehot(hold_r) && hold_level_r <= 2'h1)
        else $error("bad hold state");

    // A held port is granted at the very next edge.
    a_hold_grant: assert property (@(posedge clk_sys)
        disable iff (reset)
        (hold_r != '0) |=> ram_grant == $past(hold_r) &&
                           ram_level == $past(hold_level_r))
        else $error("held port not granted");

    // A low-level grant always follows one cycle of wait.
    a_low_wait: assert property (@(posedge clk_sys)
        disable iff (reset)
        (ram_valid && ram_level <= 2'h1) |-> $past(hold_r) == ram_grant)
        else $error("low level granted without wait");

    // A latency-class winner with no hold pending is granted at the next edge.
    a_high_direct: assert property (@(posedge clk_sys)
        disable iff (reset)
        (pick != '0 && pick_level > 2'h1 && hold_r == '0) |=>
        ram_grant == $past(pick) && ram_level == $past(pick_level))
        else $error("latency class delayed");

    // Trace buffer grant carries critical level.
    a_trace_level: assert property (@(posedge clk_sys)
        disable iff (reset) ram_grant[PORT_TRACE] |-> ram_level == 2'h3)
        else $error("trace level wrong");

    // Debug grant carries bandwidth level.
    a_debug_level: assert property (@(posedge clk_sys)
        disable iff (reset) ram_grant[PORT_DEBUG] |-> ram_level == 2'h1)
        else $error("debug level wrong");

    // Grant level matches the register for a latency-class processor winner.
    a_cpu_level: assert property (@(posedge clk_sys)
        disable iff (reset)
        (pick[PORT_CPU] && pick_level > 2'h1 && hold_r == '0)
        |=> ram_grant[PORT_CPU] && ram_level == $past(cpu_level_r))
        else $error("cpu level not carried");

    // Address phase capture of the bus slave.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_state_r <= RQA_BUS_IDLE;
            wr_pend_r   <= 1'b0;
        end else if (hready) begin
            if (hsel && htrans[1] && hits_level(haddr)) begin
                bus_state_r <= RQA_BUS_DATA;
                wr_pend_r   <= hwrite;
            end else begin
                bus_state_r <= RQA_BUS_IDLE;
                wr_pend_r   <= 1'b0;
            end
        end
    end

    // Processor level field, written in the data phase.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cpu_level_r <= `RQA_CPU_LEVEL_RST;
        end else if (bus_state_r == RQA_BUS_DATA && wr_pend_r) begin
            cpu_level_r <=
                hwdata[`RQA_CPU_LEVEL_MSB:`RQA_CPU_LEVEL_LSB];
        end
    end

    // A write still in its data phase is forwarded, so that a read right
    // behind it on the bus returns the new level instead of the old one.
    always_comb begin
        rd_level = cpu_level_r;
        if (bus_state_r == RQA_BUS_DATA && wr_pend_r) begin
            rd_level = hwdata[`RQA_CPU_LEVEL_MSB:`RQA_CPU_LEVEL_LSB];
        end
    end

    // Read data is registered at the address phase; other bits read zero.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite &&
                     hits_level(haddr)) begin
            hrdata <= {30'h0, rd_level};
        end else begin
            hrdata <= 32'h0;
        end
    end

    // Zero wait states and always OKAY.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // No requesting port outranks the winner; ties go to the lower port.
    for (genvar j = 0; j < NPORT; j++) begin : g_rank_chk
        a_rank_port: assert property (@(posedge clk_sys)
            disable iff (reset)
            (pick != '0 && req_bus.req[j]) |->
            (pick_level > req_bus.level[2*j +: 2] ||
             (pick_level == req_bus.level[2*j +: 2] &&
              int'(pick_idx) <= j)))
            else $error("lower ranked port picked");
    end

    // Any standing request produces a winner.
    a_pick_any: assert property (@(posedge clk_sys)
        disable iff (reset) (req_bus.req != '0) |-> (pick != '0))
        else $error("request without a winner");

    // The winner is never below a requesting processor.
    a_rank_level: assert property (@(posedge clk_sys)
        disable iff (reset)
        (pick != '0) |->
        (pick_level >= cpu_level_r || !req_bus.req[PORT_CPU]))
        else $error("lower level picked");

    // The processor beats the trace buffer at equal critical level.
    a_tie_low: assert property (@(posedge clk_sys)
        disable iff (reset)
        (req_bus.req[PORT_CPU] && cpu_level_r == 2'h3)
        |-> !pick[PORT_TRACE])
        else $error("tie broken wrong");

    // A register write lands in the level field at the next edge.
    a_level_write: assert property (@(posedge clk_sys)
        disable iff (reset)
        (bus_state_r == RQA_BUS_DATA && wr_pend_r)
        |=> cpu_level_r == $past(hwdata[1:0]))
        else $error("level write lost");

    // The processor level leaves reset as background.
    a_level_reset: assert property (@(posedge clk_sys)
        $fell(reset) |-> cpu_level_r == 2'h0)
        else $error("level not reset");

    // Reads return the level in the low bits and zero above.
    a_read_upper: assert property (@(posedge clk_sys)
        disable iff (reset) hrdata[31:2] == 30'h0)
        else $error("upper read bits set");

    // A read with no write in flight returns the stored level.
    a_read_level: assert property (@(posedge clk_sys)
        disable iff (reset)
        (hready && hsel && htrans[1] && !hwrite && hits_level(haddr) &&
         !(bus_state_r == RQA_BUS_DATA && wr_pend_r))
        |=> hrdata[1:0] == $past(cpu_level_r))
        else $error("read level wrong");

    // The slave never stalls and always answers OKAY.
    a_bus_okay: assert property (@(posedge clk_sys)
        disable iff (reset) hreadyout && !hresp)
        else $error("wait state or error response");

endmodule : rqa_arbiter

// *** verification/rqa_masters.sv ***
`timescale 1ns/10ps
// Bus masters that hold a request until it is granted.
module rqa_masters (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [4:0] want,
    input  wire logic [4:0] ram_grant,
    output logic      [4:0] ram_req
);
    logic [4:0] pend_r; // Requests raised and not yet served.

    // A request stands until its grant, then drops at once.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pend_r <= 5'h0;
        end else begin
            pend_r <= (pend_r | want) & ~ram_grant;
        end
    end

    // Hide a request in its grant cycle so it is not served twice.
    assign ram_req = pend_r & ~ram_grant;
endmodule : rqa_masters

// *** verification/test_ram_qos_port_arbiter.sv ***
`timescale 1ns/10ps
`include "rqa_defs.svh"
// Drives the bus and the masters, notes each expected grant in a queue.
module test_ram_qos_port_arbiter;
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
miscompares++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
end end
    logic clk_sys, reset, hsel, hwrite, hreadyout, hresp, ram_valid;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, dma_level, can_level, ram_level;
    logic [2:0]  hsize;
    logic [4:0]  want, ram_req, ram_grant, done;
    logic [6:0]  exp_g;      // Grant bits above the level.
    logic [6:0]  expq[$];    // Expected grants, oldest first.
    logic [1:0]  lv[5];      // Expected level of each port.
    int          miscompares, checks_done, b, i, n;

    rqa_arbiter dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ram_req(ram_req),
        .dma_level(dma_level), .can_level(can_level),
        .ram_grant(ram_grant), .ram_level(ram_level), .ram_valid(ram_valid));
    rqa_masters masters (.clk_sys(clk_sys), .reset(reset), .want(want),
        .ram_grant(ram_grant), .ram_req(ram_req));

    // The clock runs at 50 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // One bounded wait step; a spent bound ends the run.
    task automatic tick(inout int k);
        k++;
        if (k > 50) begin
            miscompares++;
            report_and_stop();
        end else begin
            @(negedge clk_sys);
        end
    endtask : tick

    // One single word transfer, each phase held until ready.
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        k = 0;
        @(negedge clk_sys);
        while (hreadyout !== 1'b1) tick(k);
        @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        k = 0;
        @(negedge clk_sys);
        while (hreadyout !== 1'b1) tick(k);
        r = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask : bus

    // One lone request; checks the wait from request to grant.
    task automatic single(input int p, input logic [1:0] l);
        int k;
        expq.push_back({5'(1 << p), l});
        @(posedge clk_sys);
        want <= 5'(1 << p);
        @(posedge clk_sys);
        want <= 5'h0;
        k = 0;
        @(negedge clk_sys);
        while (ram_valid !== 1'b1) tick(k);
        `CHK("latency", (l < 2'h2) ? 2 : 1, k)
    endtask : single

    // Takes the oldest note whenever a grant appears.
    always @(negedge clk_sys) begin
        if (reset === 1'b0 && ram_valid === 1'b1) begin
            if (expq.size() == 0) begin
                `CHK("valid", 1'b0, ram_valid)
            end else begin
                exp_g = expq.pop_front();
                `CHK("grant", exp_g[6:2], ram_grant)
                `CHK("level", exp_g[1:0], ram_level)
            end
        end
    end

    // Main sequence: registers, lone requests, then contention.
    initial begin
        reset = 1'b1;
        {hsel, hwrite, haddr, hwdata} = '0;
        {dma_level, can_level} = 4'h0;
        hsize = 3'h2;
        want = 5'h0;
        htrans = 2'h0;
        void'($urandom(32'hc4cb));
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        bus(1'b1, `RQA_CPU_LEVEL_ADDR + 4, 32'hffffffff, rd);
        bus(1'b0, `RQA_CPU_LEVEL_ADDR + 4, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        bus(1'b0, `RQA_CPU_LEVEL_ADDR, 32'h0, rd);
        `CHK("cpu_reset", 32'h0, rd)
        for (i = 0; i < 4; i++) begin
            bus(1'b1, `RQA_CPU_LEVEL_ADDR, {30'($urandom), 2'(i)}, rd);
            bus(1'b0, `RQA_CPU_LEVEL_ADDR, 32'h0, rd);
            `CHK("cpu_level", {30'h0, 2'(i)}, rd)
            single(0, 2'(i));
        end
        single(1, 2'h3);
        single(2, 2'h1);
        for (i = 0; i < 5; i++) begin
            // The memory controller and CAN masters set their own levels.
            lv = '{2'($urandom), 2'h3, 2'h1, 2'($urandom), 2'($urandom)};
            bus(1'b1, `RQA_CPU_LEVEL_ADDR, {30'h0, lv[0]}, rd);
            @(posedge clk_sys);
            dma_level <= lv[3];
            can_level <= lv[4];
            if (i == 0) begin
                single(3, lv[3]);
                single(4, lv[4]);
            end
            done = 5'h0;
            repeat (5) begin
                b = -1;
                for (int k = 0; k < 5; k++)
                    if (!done[k] && (b < 0 || lv[k] > lv[b])) b = k;
                done[b] = 1'b1;
                expq.push_back({5'(1 << b), lv[b]});
            end
            @(posedge clk_sys);
            want <= 5'h1f;
            @(posedge clk_sys);
            want <= 5'h0;
            n = 0;
            while (expq.size() != 0) tick(n);
        end
        // A reset in mid-run returns the processor level to background.
        bus(1'b1, `RQA_CPU_LEVEL_ADDR, 32'h3, rd);
        bus(1'b0, `RQA_CPU_LEVEL_ADDR, 32'h0, rd);
        `CHK("cpu_before_reset", 32'h3, rd)
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        bus(1'b0, `RQA_CPU_LEVEL_ADDR, 32'h0, rd);
        `CHK("cpu_after_reset", 32'h0, rd)
        single(0, 2'h0);
        repeat (5) @(posedge clk_sys);
        report_and_stop();
    end
endmodule : test_ram_qos_port_arbiter
